// ==== core/nhp_pkg.sv ====
// Package with register map, field layouts and modes of the parity report block
package nhp_pkg;
  localparam logic [7:0]  PR_FIRST_OFS   = 8'h0c;
  localparam logic [7:0]  PR_SECOND_OFS  = 8'h10;
  localparam logic [7:0]  SR_UPPER_OFS   = 8'h14;
  localparam logic [31:0] REG_RESET      = 32'h0000_0000;
  localparam logic [2:0]  MODE_PAGE      = 3'h0;
  localparam logic [2:0]  MODE_S256      = 3'h1;
  localparam logic [2:0]  MODE_S512      = 3'h2;
  localparam int          BIT_W          = 3;
  localparam int          PG_WORD_W      = 12;
  localparam int          PG_WORD_LSB    = 4;
  localparam int          PG_PAR_W       = 16;
  localparam int          S256_WORD_W    = 8;
  localparam int          S256_PAR_W     = 11;
  localparam int          S256_PAR_LSB   = 12;
  localparam int          S512_WORD_W    = 9;
  localparam int          S512_PAR_W     = 12;
  localparam int          S512_PAR_LSB   = 12;
  localparam int          WORD_LSB       = 3;
endpackage

// ==== core/nhp_report.sv ====
// Parity and error location report registers with a classic Wishbone slave
// How it works
// - Mode field 0,1,2 selects per page, 256-byte or 512-byte sector layout.
// - Page mode: first register holds 12-bit word address at 15:4, bit offset below.
// - Page mode word address counts 8-bit or 16-bit words per memory width.
// - Page mode: second register holds 16-bit parity, upper half reads zero.
// - 256 mode: first register holds sector 0 parity at 22:12, word, bit.
// - 256 mode: second register same layout for bytes 256 to 511.
// - 512 mode: first register holds 12-bit parity at 23:12, 9-bit word, bit.
// - 512 mode: second register same layout for bytes 512 to 1023.
// - Sector mode word address counts bytes within the sector.
// - After a single-error read the bit field holds the corrupt bit position.
// - Location fields loaded only on single error; ignore on multiple errors.
//
// Decided for this implementation: the Wishbone slave port.
module nhp_report (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic        wb_we_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic [2:0]  correction_granularity_i,
  input  wire logic        bus_16bit_i,
  input  wire logic        cmd_detect_i,
  input  wire logic        parity_valid_i,
  input  wire logic [15:0] page_parity_value_i,
  input  wire logic [11:0] sector_a_parity_i,
  input  wire logic [11:0] sector_b_parity_i,
  input  wire logic        check_valid_i,
  input  wire logic [1:0]  single_error_i,
  input  wire logic [1:0]  multi_error_i,
  input  wire logic [11:0] sector_a_error_word_i,
  input  wire logic [11:0] sector_b_error_word_i,
  input  wire logic [2:0]  sector_a_error_bit_i,
  input  wire logic [2:0]  sector_b_error_bit_i,
  input  wire logic [31:0] upper_sector_error_status_i,
  output logic      [2:0]  correction_granularity_o,
  output logic             single_error_flag_first_o
);

  logic [11:0] par_a_r;
  logic [11:0] par_a_nxt;
  logic [11:0] par_b_r;
  logic [11:0] par_b_nxt;
  logic [15:0] page_par_r;
  logic [15:0] page_par_nxt;
  logic [11:0] word_a_r;
  logic [11:0] word_a_nxt;
  logic [11:0] word_b_r;
  logic [11:0] word_b_nxt;
  logic [2:0]  bit_a_r;
  logic [2:0]  bit_a_nxt;
  logic [2:0]  bit_b_r;
  logic [2:0]  bit_b_nxt;
  logic [2:0]  mode_r;
  logic        sngl_r;
  logic        sngl_nxt;
  logic [31:0] upper_r;

  // Sector layout: parity, word address, bit offset; a zero bit between parity and word only in 256 mode
  function automatic logic [31:0] sector_word(input logic [2:0] mode, input logic [11:0] par,
                                               input logic [11:0] wrd, input logic [2:0] bo);
    logic [31:0] v;
    v = 32'h0000_0000;
    if (mode == nhp_pkg::MODE_S256) begin
      v[nhp_pkg::S256_PAR_LSB +: nhp_pkg::S256_PAR_W] = par[10:0];
      v[nhp_pkg::WORD_LSB +: nhp_pkg::S256_WORD_W]    = wrd[7:0];
    end else begin
      v[nhp_pkg::S512_PAR_LSB +: nhp_pkg::S512_PAR_W] = par;
      v[nhp_pkg::WORD_LSB +: nhp_pkg::S512_WORD_W]    = wrd[8:0];
    end
    v[nhp_pkg::BIT_W-1:0] = bo;
    return v;
  endfunction

  wire         mode_page = (mode_r == nhp_pkg::MODE_PAGE);
  wire         mode_sect = (mode_r == nhp_pkg::MODE_S256) || (mode_r == nhp_pkg::MODE_S512);
  wire         hit_first  = (wb_adr_i == nhp_pkg::PR_FIRST_OFS);
  wire         hit_second = (wb_adr_i == nhp_pkg::PR_SECOND_OFS);
  wire         hit_upper  = (wb_adr_i == nhp_pkg::SR_UPPER_OFS);
  wire         req        = wb_cyc_i && wb_stb_i && !wb_ack_o;
  // Page word address: in 16-bit parts the low byte-address bit joins the bit offset
  wire  [11:0] pg_word    = bus_16bit_i ? {1'b0, word_a_r[11:1]} : word_a_r;
  wire  [3:0]  pg_bit     = bus_16bit_i ? {word_a_r[0], bit_a_r} : {1'b0, bit_a_r};
  wire  [31:0] first_page = {16'h0000, pg_word, pg_bit};
  wire  [31:0] second_page = {16'h0000, page_par_r};
  wire  [31:0] first_val  = mode_page ? first_page :
                            mode_sect ? sector_word(mode_r, par_a_r, word_a_r, bit_a_r) :
                            32'h0000_0000;
  wire  [31:0] second_val = mode_page ? second_page :
                            mode_sect ? sector_word(mode_r, par_b_r, word_b_r, bit_b_r) :
                            32'h0000_0000;
  wire  [31:0] rd_val;

  // Read mux; writes and unmapped offsets return zero
  assign rd_val = wb_we_i    ? 32'h0000_0000 :
                  hit_first  ? first_val :
                  hit_second ? second_val :
                  hit_upper  ? upper_r :
                  32'h0000_0000;

  // Parity capture after a page write
  assign par_a_nxt    = parity_valid_i ? sector_a_parity_i : par_a_r;
  assign par_b_nxt    = parity_valid_i ? sector_b_parity_i : par_b_r;
  assign page_par_nxt = parity_valid_i ? page_parity_value_i : page_par_r;

  // Location loaded only for a single, not multiple, error
  assign word_a_nxt = cmd_detect_i ? 12'h000 :
                      (check_valid_i && single_error_i[0] && !multi_error_i[0]) ?
                      sector_a_error_word_i : word_a_r;
  assign bit_a_nxt  = cmd_detect_i ? 3'h0 :
                      (check_valid_i && single_error_i[0] && !multi_error_i[0]) ?
                      sector_a_error_bit_i : bit_a_r;
  assign word_b_nxt = cmd_detect_i ? 12'h000 :
                      (check_valid_i && single_error_i[1] && !multi_error_i[1]) ?
                      sector_b_error_word_i : word_b_r;
  assign bit_b_nxt  = cmd_detect_i ? 3'h0 :
                      (check_valid_i && single_error_i[1] && !multi_error_i[1]) ?
                      sector_b_error_bit_i : bit_b_r;
  // Set wins over the clear from a new command
  assign sngl_nxt   = (check_valid_i && single_error_i[0] && !multi_error_i[0]) ? 1'b1 :
                      cmd_detect_i ? 1'b0 : sngl_r;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      par_a_r    <= 12'h000;
      par_b_r    <= 12'h000;
      page_par_r <= 16'h0000;
      word_a_r   <= 12'h000;
      word_b_r   <= 12'h000;
      bit_a_r    <= 3'h0;
      bit_b_r    <= 3'h0;
      sngl_r     <= 1'b0;
    end else begin
      par_a_r    <= par_a_nxt;
      par_b_r    <= par_b_nxt;
      page_par_r <= page_par_nxt;
      word_a_r   <= word_a_nxt;
      word_b_r   <= word_b_nxt;
      bit_a_r    <= bit_a_nxt;
      bit_b_r    <= bit_b_nxt;
      sngl_r     <= sngl_nxt;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode_r                    <= nhp_pkg::MODE_PAGE;
      upper_r                   <= nhp_pkg::REG_RESET;
      correction_granularity_o  <= nhp_pkg::MODE_PAGE;
      single_error_flag_first_o <= 1'b0;
    end else begin
      mode_r                    <= correction_granularity_i;
      upper_r                   <= upper_sector_error_status_i;
      correction_granularity_o  <= mode_r;
      single_error_flag_first_o <= sngl_nxt;
    end
  end

  // Wishbone slave: one wait state, ack for any address, write ignored
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= nhp_pkg::REG_RESET;
    end else begin
      wb_ack_o <= req;
      wb_dat_o <= req ? rd_val : 32'h0000_0000;
    end
  end

endmodule

// ==== verif/nhp_nand_model.sv ====
// Page data stream model issuing command and capture strobes
module nhp_nand_model (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       go_i,
  input  wire logic       rd_i,
  input  wire logic [3:0] gap_i,
  output logic            cmd_o,
  output logic            pv_o,
  output logic            cv_o,
  output logic            done_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] cnt = 4'h0;
  logic       rd_r = 1'b0;
  initial {cmd_o, pv_o, cv_o} = 3'h0;
  assign done_o = cnt == 4'h0 && !pv_o && !cv_o;
  always @(posedge clk_i) begin
    cmd_o <= go_i && !rst_i;
    pv_o <= cnt == 4'h1 && !rd_r;
    cv_o <= cnt == 4'h1 && rd_r;
    if (rst_i) cnt <= 4'h0;
    else if (go_i) {cnt, rd_r} <= {gap_i, rd_i};
    else if (cnt != 4'h0) cnt <= cnt - 4'h1;
  end
endmodule

// ==== verif/nhp_props.sv ====
// Checker for the parity report block
module nhp_props (
  input wire logic       clk_i,
  input wire logic       rst_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic       wb_we_i,
  input wire logic       wb_cyc_i,
  input wire logic       wb_stb_i,
  input wire logic[31:0] wb_dat_o,
  input wire logic       wb_ack_o,
  input wire logic [2:0] correction_granularity_i,
  input wire logic [2:0] correction_granularity_o,
  input wire logic       cmd_detect_i,
  input wire logic       check_valid_i,
  input wire logic [1:0] single_error_i,
  input wire logic [1:0] multi_error_i,
  input wire logic       single_error_flag_first_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  wire req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire set0 = check_valid_i && single_error_i[0] && !multi_error_i[0];
  wire mapd = wb_adr_i == nhp_pkg::PR_FIRST_OFS || wb_adr_i == nhp_pkg::PR_SECOND_OFS
              || wb_adr_i == nhp_pkg::SR_UPPER_OFS;
  a_ack_next: assert property (req |=> wb_ack_o) else $error("ack late");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held");
  a_idle_zero: assert property (!wb_ack_o |-> wb_dat_o == 0) else $error("data idle");
  a_write_zero: assert property (req && wb_we_i |=> wb_dat_o == 0) else $error("write data");
  a_unmapped_zero: assert property (req && !mapd |=> wb_dat_o == 0) else $error("unmapped");
  a_mode_track: assert property (!$past(rst_i) && !$past(rst_i, 2) |->
    correction_granularity_o == $past(correction_granularity_i, 2)) else $error("mode");
  a_flag_set: assert property (set0 |=> single_error_flag_first_o) else $error("flag set");
  a_flag_clear: assert property (cmd_detect_i && !set0 |=> !single_error_flag_first_o)
    else $error("flag clear");
  a_flag_hold: assert property (!cmd_detect_i && !check_valid_i |=>
    $stable(single_error_flag_first_o)) else $error("flag moved");
endmodule
bind nhp_report nhp_props nhp_props_inst (.*);

// ==== verif/nhp_report_tb_top.sv ====
// Self-checking bench for the parity report block
module nhp_report_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 0, rst_i = 1, wb_we_i = 0, wb_cyc_i = 0, wb_stb_i = 0, bus_16bit_i = 0;
  logic cmd_detect_i, parity_valid_i, check_valid_i, done, go = 0, rd = 0, flg = 0;
  logic wb_ack_o, single_error_flag_first_o;
  logic [7:0] wb_adr_i = 0, spare[1024];
  logic [3:0] wb_sel_i = 4'hf, gap = 4'h1;
  logic [31:0] wb_dat_i = 0, wb_dat_o, upper_sector_error_status_i = 0, d;
  logic [2:0] correction_granularity_i = 0, correction_granularity_o, ab = 0, bb = 0;
  logic [2:0] sector_a_error_bit_i = 0, sector_b_error_bit_i = 0;
  logic [1:0] single_error_i = 0, multi_error_i = 0;
  logic [15:0] page_parity_value_i = 0, pp = 0;
  logic [11:0] sector_a_parity_i = 0, sector_b_parity_i = 0, pa = 0, pb = 0, aw = 0, bw = 0;
  logic [11:0] sector_a_error_word_i = 0, sector_b_error_word_i = 0;
  logic [7:0] ofs[4] = '{nhp_pkg::PR_FIRST_OFS, nhp_pkg::PR_SECOND_OFS,
                         nhp_pkg::SR_UPPER_OFS, 8'h20};
  int n_mismatch = 0, check_count = 0;
  nhp_report nhp_report_inst (.*);
  nhp_nand_model nhp_nand_model_inst (.clk_i, .rst_i, .go_i(go), .rd_i(rd), .gap_i(gap),
    .cmd_o(cmd_detect_i), .pv_o(parity_valid_i), .cv_o(check_valid_i), .done_o(done));
  always #5 clk_i = ~clk_i;
  task automatic give_verdict;
    if (n_mismatch == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic wb(input logic [7:0] a, input logic w);
    @(posedge clk_i);
    {wb_adr_i, wb_we_i, wb_cyc_i, wb_stb_i, wb_dat_i} <= {a, w, 2'b11, 32'($urandom)};
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    d = wb_dat_o;
    {wb_cyc_i, wb_stb_i} <= 2'b00;
  endtask
  function automatic logic [31:0] expv(input logic [7:0] a);
    logic [11:0] w, p;
    logic [2:0] b;
    logic [3:0] bp;
    {w, p, b} = (a == nhp_pkg::PR_FIRST_OFS) ? {aw, pa, ab} : {bw, pb, bb};
    if (a == nhp_pkg::SR_UPPER_OFS) return upper_sector_error_status_i;
    if (a != nhp_pkg::PR_FIRST_OFS && a != nhp_pkg::PR_SECOND_OFS) return 0;
    bp = {1'b0, b};
    if (bus_16bit_i && correction_granularity_i == nhp_pkg::MODE_PAGE) begin
      bp = {w[0], b};
      w = w >> 1;
    end
    case (correction_granularity_i)
      nhp_pkg::MODE_PAGE: return (a == nhp_pkg::PR_SECOND_OFS) ? {16'h0000, pp}
                                                              : {16'h0000, w, bp};
      nhp_pkg::MODE_S256: return {9'h000, p[10:0], 1'b0, w[7:0], b};
      nhp_pkg::MODE_S512: return {8'h00, p, w[8:0], b};
      default: return 0;
    endcase
  endfunction
  task automatic run(input logic r);
    @(posedge clk_i);
    {go, rd, gap} <= {1'b1, r, 4'($urandom_range(1, 15))};
    @(posedge clk_i);
    go <= 0;
    do @(posedge clk_i); while (done !== 1'b1);
    {aw, bw, ab, bb, flg} = 0;
    if (!r) {pp, pa, pb} = {page_parity_value_i, sector_a_parity_i, sector_b_parity_i};
    if (r && single_error_i[0] && !multi_error_i[0])
      {aw, ab, flg} = {sector_a_error_word_i, sector_a_error_bit_i, 1'b1};
    if (r && single_error_i[1] && !multi_error_i[1])
      {bw, bb} = {sector_b_error_word_i, sector_b_error_bit_i};
  endtask
  task automatic rd_all;
    wb(nhp_pkg::PR_FIRST_OFS, 1);
    chk(d, 0);
    foreach (ofs[k]) begin
      wb(ofs[k], 0);
      chk(d, expv(ofs[k]));
      if (k == 1) {spare[515], spare[514]} = d[15:0];
    end
    if (correction_granularity_i == nhp_pkg::MODE_PAGE)
      chk({16'h0000, spare[515], spare[514]}, {16'h0000, pp});
  endtask
  initial begin
    void'($urandom(32'hf171_434d));
    repeat (20) @(posedge clk_i);
    rst_i <= 0;
    for (int i = 0; i < 8; i++) begin
      {correction_granularity_i, bus_16bit_i} <= {3'(i % 4), i[2]};
      upper_sector_error_status_i <= $urandom;
      repeat (3) @(posedge clk_i);
      chk(32'(correction_granularity_o), 32'(i % 4));
      {page_parity_value_i, sector_a_parity_i, sector_b_parity_i} <= 40'($urandom) << 8;
      run(0);
      rd_all();
      {single_error_i, multi_error_i, sector_a_error_bit_i, sector_b_error_bit_i} <= 10'($urandom);
      {sector_a_error_word_i, sector_b_error_word_i} <= 24'($urandom);
      run(1);
      chk({31'h0, single_error_flag_first_o}, {31'h0, flg});
      rd_all();
    end
    give_verdict();
  end
  initial begin
    #200000;
    n_mismatch++;
    give_verdict();
  end
endmodule
